// file: core/synth_modulator_control_regs.sv
// Purpose: serial-port reached control bank of the modulator and synthesizer
// Assumes: sclk at most clk_sys/8; 24-bit frames, MSB first, rw bit then 7-bit address
// Notes: pins pass two flops; read MSB is driven on the eighth rising sclk, later read bits change on falling sclk
// Functional notes
// (RULE1) pump_control bit 14 picks internal (0) or external (1) pump; resets 0
// (RULE2) coarse current bits 13:10 map 1,3,7,F to 250..1000 uA; resets 3
// (RULE3) ref mux bits 6:4 routes lock, temperature, ref and ref ratios; resets 0
// (RULE4) ref input ratio bits 2:0 multiply or divide reference; resets 3
// (RULE5) oscillator regulator r4 select in bits 15:12, resets 2
// (RULE6) oscillator regulator r2 select in bits 11:8, resets A
// (RULE7) external LO amplitude bits 7:6 choose three levels; resets 0
// (RULE8) bit 5 enables halving for the external LO driver; resets 0
// (RULE9) bit 4 adds a halving stage for total LO division of eight
// (RULE10) bit 3 adds a halving stage for total LO division of four
// (RULE11) oscillator core select bits 2:0 pick four cores or external LO; resets 3
// (RULE12) balun output capacitance bits 7:4, minimum to maximum; resets 0
// (RULE13) balun input capacitance bits 3:0, minimum to maximum; resets 0
// (RULE14) linearizer resistor select bits 12:6, resets 0x44
// (RULE15) linearizer capacitor select bits 5:0, resets 0x01
// (RULE16) q polarity bits 11:10, 01 inverted, 10 normal; resets 2
// (RULE17) i polarity bits 9:8, 01 normal, 10 inverted; resets 1
// (RULE18) q sideband trim in modulator trim bits 7:4, resets 0
// (RULE19) i sideband trim in modulator trim bits 3:0, resets 0
// (RULE20) bleed top bit sink/source, low five bits magnitude, zero is none
// (RULE21) detector polarity bit 3, 0 positive, 1 negative; modulator bleed 14:12
// (RULE22) lock indication reaches the reference output when mux code is 000
`timescale 1ns/1ps
module synth_modulator_control_regs (
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst_n, // async reset, low
  input wire logic spi_cs_n, // serial select, low
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_sdio_in, // serial data pin level
  output logic spi_sdio_out, // serial read data
  output logic spi_sdio_oe, // high while driving sdio
  input wire logic lock_indication, // lock detect from PLL
  output logic ref_output_lock, // lock routed to ref output
  output logic pump_source_select, // 0 internal, 1 external
  output logic [3:0] pump_coarse_current, // coarse current code
  output logic [5:0] pump_bleed_current, // bleed code
  output logic [2:0] ref_output_select, // ref output mux
  output logic phase_detector_polarity, // 0 positive, 1 negative
  output logic [2:0] ref_input_ratio, // ref multiply/divide
  output logic [3:0] oscillator_regulator_r4_select, // regulator r4
  output logic [3:0] oscillator_regulator_r2_select, // regulator r2
  output logic [1:0] external_lo_amplitude, // LO driver level
  output logic lo_driver_halving_enable, // driver /2
  output logic lo_path_eighth_enable, // LO path to /8
  output logic lo_path_quarter_enable, // LO path to /4
  output logic [2:0] oscillator_core_select, // core or external LO
  output logic [3:0] balun_output_capacitance, // balun cout
  output logic [3:0] balun_input_capacitance, // balun cin
  output logic [6:0] linearizer_resistor_select, // linearizer r
  output logic [5:0] linearizer_capacitor_select, // linearizer c
  output logic [2:0] modulator_bleed_current, // modulator bleed
  output logic [1:0] q_channel_polarity, // q polarity code
  output logic [1:0] i_channel_polarity, // i polarity code
  output logic [3:0] q_sideband_trim, // q sideband nulling
  output logic [3:0] i_sideband_trim, // i sideband nulling
  output logic [10:0] pump_current_ua, // decoded pump current
  output logic bleed_source, // decoded bleed direction
  output logic [4:0] bleed_steps, // decoded bleed steps
  output logic bleed_active, // bleed nonzero
  output logic [3:0] lo_division, // total LO division
  output logic setting_invalid // undefined code present
);
  import synth_ctrl_pkg::*;
  // ******************************************
  // pin synchronisers
  // ******************************************
  logic [3:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic lock_s;
  pin_sync #(.W(4), .RST_VAL(4'h1)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({lock_indication, spi_sdio_in, spi_sclk, spi_cs_n}),
    .q(pins_s)
  );
  assign cs_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign lock_s = pins_s[3];
  // ******************************************
  // state
  // ******************************************
  typedef struct packed {
    spi_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [REG_W-1:0] shift;
    logic [2:0] widx;
    logic [REG_W-1:0] wdata;
    logic commit;
    logic sclk_q;
    logic sdo;
    logic oe;
    logic lock_route;
    logic first;
    logic [NUM_REGS-1:0][REG_W-1:0] regs;
  } bank_t;
  localparam bank_t BANK_RST = '{state: ST_IDLE, cnt: '0, shift: '0, widx: '0, wdata: '0,
    commit: 1'b0, sclk_q: 1'b0, sdo: 1'b0, oe: 1'b0, lock_route: 1'b0, first: 1'b1,
    regs: REGS_RESET};
  bank_t st;
  bank_t next_st;
  logic sclk_rise;
  logic sclk_fall;
  logic [3:0] look;
  logic [REG_W-1:0] word_in;
  assign sclk_rise = sclk_s & ~st.sclk_q;
  assign sclk_fall = ~sclk_s & st.sclk_q;
  assign word_in = {st.shift[REG_W-2:0], sdi_s};
  // command byte is {rw, addr}; addr completes with the eighth bit
  assign look = reg_lookup({st.shift[ADDR_W-2:0], sdi_s});
  // ******************************************
  // frame engine
  // ******************************************
  always_comb begin
    next_st = st;
    next_st.commit = 1'b0;
    next_st.first = 1'b0;
    next_st.sclk_q = sclk_s;
    // lock only appears on the ref output for mux code 000
    next_st.lock_route = lock_s && (st.regs[IDX_PFD][REF_MUX_LSB +: 3] == REF_MUX_LOCK); // see RULE22
    if (cs_s) begin
      // deselect aborts any frame; a partial write never lands
      next_st.state = ST_IDLE;
      next_st.oe = 1'b0;
      next_st.cnt = '0;
    end else begin
      case (st.state)
        ST_IDLE: begin
          next_st.state = ST_COMMAND;
          next_st.cnt = '0;
        end
        ST_COMMAND: begin
          if (sclk_rise) begin
            next_st.shift = word_in;
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_W'(CMD_BITS - 1)) begin
              next_st.cnt = '0;
              next_st.widx = look[2:0];
              if (st.shift[ADDR_W-1]) begin
                // unmapped reads return zero
                next_st.state = ST_READ;
                next_st.shift = look[3] ? st.regs[look[2:0]] : '0;
                next_st.sdo = look[3] ? st.regs[look[2:0]][REG_W-1] : 1'b0;
                next_st.oe = 1'b1;
              end else begin
                next_st.state = look[3] ? ST_WRITE : ST_DONE;
              end
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            next_st.shift = word_in;
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_W'(REG_W - 1)) begin
              // reserved bits are dropped here so they always read zero
              next_st.regs[st.widx] = word_in & REGS_MASK[st.widx]; // see RULE1, RULE5, RULE14, RULE21
              next_st.wdata = word_in;
              next_st.commit = 1'b1;
              next_st.state = ST_DONE;
            end
          end
        end
        ST_READ: begin
          if (sclk_rise) begin
            next_st.cnt = st.cnt + 1'b1;
          end else if (sclk_fall && st.cnt != '0) begin
            if (st.cnt == CNT_W'(REG_W)) begin
              next_st.oe = 1'b0;
              next_st.state = ST_DONE;
            end else begin
              next_st.sdo = st.shift[REG_W-2];
              next_st.shift = {st.shift[REG_W-2:0], 1'b0};
            end
          end
        end
        ST_DONE: begin
          next_st.state = ST_DONE;
        end
        default: begin
          next_st.state = ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= BANK_RST;
    end else begin
      st <= next_st;
    end
  end
  // ******************************************
  // field outputs
  // ******************************************
  assign spi_sdio_out = st.sdo;
  assign spi_sdio_oe = st.oe;
  assign ref_output_lock = st.lock_route;
  assign pump_source_select = st.regs[IDX_PUMP][PUMP_SRC_BIT]; // see RULE1
  assign pump_coarse_current = st.regs[IDX_PUMP][PUMP_COARSE_LSB +: 4]; // see RULE2
  assign pump_bleed_current = st.regs[IDX_PUMP][BLEED_LSB +: 6]; // see RULE20
  assign ref_output_select = st.regs[IDX_PFD][REF_MUX_LSB +: 3]; // see RULE3
  assign phase_detector_polarity = st.regs[IDX_PFD][PFD_POL_BIT]; // see RULE21
  assign ref_input_ratio = st.regs[IDX_PFD][REF_RATIO_LSB +: 3]; // see RULE4
  assign oscillator_regulator_r4_select = st.regs[IDX_OSC][R4_LSB +: 4]; // see RULE5
  assign oscillator_regulator_r2_select = st.regs[IDX_OSC][R2_LSB +: 4]; // see RULE6
  assign external_lo_amplitude = st.regs[IDX_OSC][AMP_LSB +: 2]; // see RULE7
  assign lo_driver_halving_enable = st.regs[IDX_OSC][DRV_HALF_BIT]; // see RULE8
  assign lo_path_eighth_enable = st.regs[IDX_OSC][EIGHTH_BIT]; // see RULE9
  assign lo_path_quarter_enable = st.regs[IDX_OSC][QUARTER_BIT]; // see RULE10
  assign oscillator_core_select = st.regs[IDX_OSC][CORE_LSB +: 3]; // see RULE11
  assign balun_output_capacitance = st.regs[IDX_BALUN][COUT_LSB +: 4]; // see RULE12
  assign balun_input_capacitance = st.regs[IDX_BALUN][CIN_LSB +: 4]; // see RULE13
  assign linearizer_resistor_select = st.regs[IDX_LIN][RSEL_LSB +: 7]; // see RULE14
  assign linearizer_capacitor_select = st.regs[IDX_LIN][CSEL_LSB +: 6]; // see RULE15
  assign modulator_bleed_current = st.regs[IDX_MOD][MODULATOR_BLEED_CURRENT_LSB +: 3]; // see RULE21
  assign q_channel_polarity = st.regs[IDX_MOD][POLQ_LSB +: 2]; // see RULE16
  assign i_channel_polarity = st.regs[IDX_MOD][POLI_LSB +: 2]; // see RULE17
  assign q_sideband_trim = st.regs[IDX_MOD][QTRIM_LSB +: 4]; // see RULE18
  assign i_sideband_trim = st.regs[IDX_MOD][ITRIM_LSB +: 4]; // see RULE19
  // ******************************************
  // decode
  // ******************************************
  control_decode u_decode (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pump_coarse_current(pump_coarse_current),
    .pump_bleed_current(pump_bleed_current),
    .lo_path_quarter_enable(lo_path_quarter_enable),
    .lo_path_eighth_enable(lo_path_eighth_enable),
    .ref_output_select(ref_output_select),
    .ref_input_ratio(ref_input_ratio),
    .oscillator_core_select(oscillator_core_select),
    .external_lo_amplitude(external_lo_amplitude),
    .q_channel_polarity(q_channel_polarity),
    .i_channel_polarity(i_channel_polarity),
    .pump_current_ua(pump_current_ua),
    .bleed_source(bleed_source),
    .bleed_steps(bleed_steps),
    .bleed_active(bleed_active),
    .lo_division(lo_division),
    .setting_invalid(setting_invalid)
  );
  // ******************************************
  // checks
  // ******************************************
  a_reset_pump: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE1
    st.first |-> !pump_source_select && pump_coarse_current == 4'h3 && pump_bleed_current == 6'h26)
    else $error("pump control not at reset value");
  a_reset_osc: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE5
    st.first |-> oscillator_regulator_r4_select == 4'h2 && oscillator_regulator_r2_select == 4'ha &&
      oscillator_core_select == 3'h3)
    else $error("oscillator control not at reset value");
  a_reset_lin: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE14
    st.first |-> linearizer_resistor_select == 7'h44 && linearizer_capacitor_select == 6'h01)
    else $error("linearizer not at reset value");
  a_reset_pol: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE16
    st.first |-> q_channel_polarity == 2'h2 && i_channel_polarity == 2'h1 && phase_detector_polarity)
    else $error("polarity fields not at reset value");
  a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE19
    st.commit |-> st.regs[st.widx] == (st.wdata & REGS_MASK[st.widx]) && $past(st.state) == ST_WRITE)
    else $error("written word not stored");
  a_regs_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE12
    !st.commit |-> $stable(st.regs))
    else $error("register changed without a write");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE21
    (st.regs & ~REGS_MASK) == '0)
    else $error("reserved bit set");
  a_lock_route: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE22
    (lock_s && ref_output_select == REF_MUX_LOCK) |=> ref_output_lock)
    else $error("lock not routed on code 000");
  a_release_sdio: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE3
    cs_s |=> !spi_sdio_oe)
    else $error("sdio driven while deselected");
  // st.first is high only at the first edge out of reset, so these check the power-on map once per reset
  a_reset_ref: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE4
    st.first |-> ref_output_select == REF_MUX_LOCK && ref_input_ratio == 3'h3)
    else $error("reference fields not at reset value");
  a_reset_lo: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE7
    st.first |-> external_lo_amplitude == 2'h0 && !lo_driver_halving_enable && !lo_path_eighth_enable &&
      !lo_path_quarter_enable)
    else $error("LO path fields not at reset value");
  a_reset_balun: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE13
    st.first |-> balun_output_capacitance == 4'h0 && balun_input_capacitance == 4'h0)
    else $error("balun fields not at reset value");
  a_reset_trim: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE18
    st.first |-> q_sideband_trim == 4'h0 && i_sideband_trim == 4'h0 && modulator_bleed_current == 3'h0)
    else $error("trim fields not at reset value");
  a_lock_block: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE22
    (ref_output_select != REF_MUX_LOCK) |=> !ref_output_lock)
    else $error("lock routed on another mux code");
  c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) st.commit);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(spi_sdio_oe));
  c_lock: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ref_output_lock));
  c_abort: cover property (@(posedge clk_sys) disable iff (!rst_n) st.state == ST_WRITE && cs_s);
endmodule : synth_modulator_control_regs

// file: core/synth_ctrl_pkg.sv
// Purpose: shared constants, map and helpers of the synthesizer/modulator control bank
// Assumes: 7-bit register addresses, 16-bit registers, 24-bit serial frames
// Notes: offsets are word addresses on the serial port
package synth_ctrl_pkg;
  localparam int NUM_REGS = 6;
  localparam int REG_W = 16;
  localparam int ADDR_W = 7;
  localparam int CMD_BITS = 8;
  localparam int CNT_W = 5;
  // ******************************************
  // register map
  // ******************************************
  localparam logic [6:0] PUMP_CONTROL_OFFSET = 7'h20;
  localparam logic [6:0] PHASE_DETECTOR_CONTROL_OFFSET = 7'h21;
  localparam logic [6:0] OSCILLATOR_CONTROL_OFFSET = 7'h22;
  localparam logic [6:0] BALUN_TUNING_OFFSET = 7'h30;
  localparam logic [6:0] LINEARIZER_CONTROL_OFFSET = 7'h31;
  localparam logic [6:0] MODULATOR_TRIM_CONTROL_OFFSET = 7'h32;
  localparam logic [2:0] IDX_PUMP = 3'h0;
  localparam logic [2:0] IDX_PFD = 3'h1;
  localparam logic [2:0] IDX_OSC = 3'h2;
  localparam logic [2:0] IDX_BALUN = 3'h3;
  localparam logic [2:0] IDX_LIN = 3'h4;
  localparam logic [2:0] IDX_MOD = 3'h5;
  // index 5 down to 0
  localparam logic [NUM_REGS-1:0][REG_W-1:0] REGS_RESET =
    {16'h0900, 16'h1101, 16'h0000, 16'h2a03, 16'h000b, 16'h0c26};
  // reserved bits stay zero
  localparam logic [NUM_REGS-1:0][REG_W-1:0] REGS_MASK =
    {16'h7fff, 16'h1fff, 16'h00ff, 16'hffff, 16'h007f, 16'h7c3f};
  // ******************************************
  // field positions
  // ******************************************
  localparam int PUMP_SRC_BIT = 14;
  localparam int PUMP_COARSE_LSB = 10;
  localparam int BLEED_LSB = 0;
  localparam int BLEED_SRC_BIT = 5;
  localparam int REF_MUX_LSB = 4;
  localparam int PFD_POL_BIT = 3;
  localparam int REF_RATIO_LSB = 0;
  localparam int R4_LSB = 12;
  localparam int R2_LSB = 8;
  localparam int AMP_LSB = 6;
  localparam int DRV_HALF_BIT = 5;
  localparam int EIGHTH_BIT = 4;
  localparam int QUARTER_BIT = 3;
  localparam int CORE_LSB = 0;
  localparam int COUT_LSB = 4;
  localparam int CIN_LSB = 0;
  localparam int RSEL_LSB = 6;
  localparam int CSEL_LSB = 0;
  localparam int MODULATOR_BLEED_CURRENT_LSB = 12;
  localparam int POLQ_LSB = 10;
  localparam int POLI_LSB = 8;
  localparam int QTRIM_LSB = 4;
  localparam int ITRIM_LSB = 0;
  // ******************************************
  // code values
  // ******************************************
  localparam logic [3:0] COARSE_250 = 4'h1;
  localparam logic [3:0] COARSE_500 = 4'h3;
  localparam logic [3:0] COARSE_750 = 4'h7;
  localparam logic [3:0] COARSE_1000 = 4'hf;
  localparam logic [10:0] UA_250 = 11'h0fa;
  localparam logic [10:0] UA_500 = 11'h1f4;
  localparam logic [10:0] UA_750 = 11'h2ee;
  localparam logic [10:0] UA_1000 = 11'h3e8;
  localparam logic [3:0] DIV_BASE = 4'h2;
  localparam logic [3:0] DIV_QUARTER = 4'h4;
  localparam logic [3:0] DIV_EIGHTH = 4'h8;
  localparam logic [2:0] REF_MUX_LOCK = 3'h0;
  localparam logic [2:0] REF_MUX_MAX = 3'h6;
  localparam logic [2:0] REF_RATIO_MAX = 3'h4;
  localparam logic [2:0] CORE_MAX = 3'h4;
  localparam logic [1:0] AMP_MAX = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_COMMAND, ST_WRITE, ST_READ, ST_DONE} spi_state_t;

  // {hit, index}
  function automatic logic [3:0] reg_lookup(input logic [ADDR_W-1:0] a);
    case (a)
      PUMP_CONTROL_OFFSET: reg_lookup = {1'b1, IDX_PUMP};
      PHASE_DETECTOR_CONTROL_OFFSET: reg_lookup = {1'b1, IDX_PFD};
      OSCILLATOR_CONTROL_OFFSET: reg_lookup = {1'b1, IDX_OSC};
      BALUN_TUNING_OFFSET: reg_lookup = {1'b1, IDX_BALUN};
      LINEARIZER_CONTROL_OFFSET: reg_lookup = {1'b1, IDX_LIN};
      MODULATOR_TRIM_CONTROL_OFFSET: reg_lookup = {1'b1, IDX_MOD};
      default: reg_lookup = 4'h0;
    endcase
  endfunction : reg_lookup

  // only 01 and 10 are meaningful polarity codes
  function automatic logic pol_valid(input logic [1:0] c);
    pol_valid = c[1] ^ c[0];
  endfunction : pol_valid
endpackage : synth_ctrl_pkg

// file: core/pin_sync.sv
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: pins idle at the given reset level
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic [W-1:0] d, // raw pins
  output logic [W-1:0] q // synchronised
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st;
  sync_t next_st;
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end
  assign q = st.s2;
endmodule : pin_sync

// file: core/control_decode.sv
// Purpose: registered decode of analog control fields into readable quantities
// Assumes: fields come from flops on the same clock
// Notes: one cycle behind the register bank
`timescale 1ns/1ps
module control_decode (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic [3:0] pump_coarse_current, // coarse code
  input wire logic [5:0] pump_bleed_current, // bleed code
  input wire logic lo_path_quarter_enable, // extra /2 to /4
  input wire logic lo_path_eighth_enable, // extra /2 to /8
  input wire logic [2:0] ref_output_select, // ref mux code
  input wire logic [2:0] ref_input_ratio, // ref ratio code
  input wire logic [2:0] oscillator_core_select, // core code
  input wire logic [1:0] external_lo_amplitude, // amp code
  input wire logic [1:0] q_channel_polarity, // q pol code
  input wire logic [1:0] i_channel_polarity, // i pol code
  output logic [10:0] pump_current_ua, // pump current, uA
  output logic bleed_source, // 1 source, 0 sink
  output logic [4:0] bleed_steps, // bleed in 15.625 uA steps
  output logic bleed_active, // nonzero bleed
  output logic [3:0] lo_division, // total LO division
  output logic setting_invalid // some field holds an undefined code
);
  import synth_ctrl_pkg::*;
  typedef struct packed {
    logic [10:0] ua;
    logic src;
    logic [4:0] steps;
    logic active;
    logic [3:0] div;
    logic bad;
  } dec_t;
  dec_t st;
  dec_t next_st;
  always_comb begin
    next_st = st;
    case (pump_coarse_current) // see RULE2
      COARSE_250: next_st.ua = UA_250;
      COARSE_500: next_st.ua = UA_500;
      COARSE_750: next_st.ua = UA_750;
      COARSE_1000: next_st.ua = UA_1000;
      default: next_st.ua = '0;
    endcase
    next_st.src = pump_bleed_current[BLEED_SRC_BIT]; // see RULE20
    next_st.steps = pump_bleed_current[BLEED_SRC_BIT-1:0];
    next_st.active = |pump_bleed_current[BLEED_SRC_BIT-1:0];
    if (lo_path_eighth_enable) begin // see RULE9
      next_st.div = DIV_EIGHTH;
    end else if (lo_path_quarter_enable) begin // see RULE10
      next_st.div = DIV_QUARTER;
    end else begin
      next_st.div = DIV_BASE;
    end
    next_st.bad = (next_st.ua == '0) || (ref_output_select > REF_MUX_MAX) ||
      (ref_input_ratio > REF_RATIO_MAX) || (oscillator_core_select > CORE_MAX) ||
      (external_lo_amplitude > AMP_MAX) || !pol_valid(q_channel_polarity) ||
      !pol_valid(i_channel_polarity);
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ua: UA_500, src: 1'b1, steps: 5'h06, active: 1'b1, div: DIV_BASE, bad: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign pump_current_ua = st.ua;
  assign bleed_source = st.src;
  assign bleed_steps = st.steps;
  assign bleed_active = st.active;
  assign lo_division = st.div;
  assign setting_invalid = st.bad;

  a_coarse_map: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
    (pump_coarse_current == COARSE_1000) |=> (pump_current_ua == UA_1000))
    else $error("coarse code 1111 not 1000 uA");
  a_bleed_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE20
    (pump_bleed_current[4:0] == 5'h00) |=> !bleed_active && bleed_steps == 5'h00)
    else $error("zero bleed magnitude still active");
  a_lo_divide: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE10
    (lo_path_quarter_enable && !lo_path_eighth_enable) |=> (lo_division == DIV_QUARTER))
    else $error("quarter path not dividing by four");
endmodule : control_decode

// file: test/tb.sv
// Purpose: self-checking bench of the synthesizer/modulator control bank
// Assumes: 3-wire serial frames, 4 clk per sclk phase
// Notes: sdio wire is resolved from the block's enable
`timescale 1ns/1ps
module tb;
  import synth_ctrl_pkg::*;
  logic clk_sys, rst_n, cs_n, sclk, host, lock;
  logic sd_out, sd_oe, lock_out, src, act, bad;
  logic [10:0] ua;
  logic [3:0] div;
  logic [15:0] rd;
  logic [4:0] stp;
  // field outputs laid back into register words; reserved bits have no port and are tied low
  wire logic [5:0][15:0] fw;
  assign {fw[0][15], fw[0][9:6], fw[1][15:7], fw[3][15:8], fw[4][15:13], fw[5][15]} = 26'h0;
  int err_count, n_compared;
  wire logic sdio = sd_oe ? sd_out : host;
  logic [6:0] ofs [6] = '{PUMP_CONTROL_OFFSET, PHASE_DETECTOR_CONTROL_OFFSET, OSCILLATOR_CONTROL_OFFSET,
    BALUN_TUNING_OFFSET, LINEARIZER_CONTROL_OFFSET, MODULATOR_TRIM_CONTROL_OFFSET};
  logic [15:0] rv [6] = '{16'h0c26, 16'h000b, 16'h2a03, 16'h0000, 16'h1101, 16'h0900};
  logic [15:0] mk [6] = '{16'h7c3f, 16'h007f, 16'hffff, 16'h00ff, 16'h1fff, 16'h7fff};
  logic [3:0] cc [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
  logic [10:0] cu [4] = '{11'h0fa, 11'h1f4, 11'h2ee, 11'h3e8};
  synth_modulator_control_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_sdio_in(sdio), .spi_sdio_out(sd_out), .spi_sdio_oe(sd_oe), .lock_indication(lock),
    .ref_output_lock(lock_out), .pump_source_select(fw[0][14]), .pump_coarse_current(fw[0][13:10]),
    .pump_bleed_current(fw[0][5:0]), .ref_output_select(fw[1][6:4]), .phase_detector_polarity(fw[1][3]),
    .ref_input_ratio(fw[1][2:0]), .oscillator_regulator_r4_select(fw[2][15:12]),
    .oscillator_regulator_r2_select(fw[2][11:8]), .external_lo_amplitude(fw[2][7:6]),
    .lo_driver_halving_enable(fw[2][5]), .lo_path_eighth_enable(fw[2][4]), .lo_path_quarter_enable(fw[2][3]),
    .oscillator_core_select(fw[2][2:0]), .balun_output_capacitance(fw[3][7:4]),
    .balun_input_capacitance(fw[3][3:0]), .linearizer_resistor_select(fw[4][12:6]),
    .linearizer_capacitor_select(fw[4][5:0]), .modulator_bleed_current(fw[5][14:12]),
    .q_channel_polarity(fw[5][11:10]), .i_channel_polarity(fw[5][9:8]), .q_sideband_trim(fw[5][7:4]),
    .i_sideband_trim(fw[5][3:0]), .pump_current_ua(ua), .bleed_source(src), .bleed_steps(stp),
    .bleed_active(act), .lo_division(div), .setting_invalid(bad));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ******************************
  // tasks
  // ******************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // one frame, cut after nb bits when nb is below 24; the last 16 bits seen on sdio land in rd
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d, input int nb = 24);
    logic [23:0] f;
    f = {rw, a, d};
    cs_n <= 1'b0;
    cyc(4);
    for (int i = 23; i >= 24 - nb; i--) begin
      host <= f[i];
      cyc(4);
      rd = {rd[14:0], sdio};
      sclk <= 1'b1;
      cyc(4);
      sclk <= 1'b0;
    end
    cyc(4);
    cs_n <= 1'b1;
    cyc(6);
  endtask : xfer
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // ******************************
  // sequence
  // ******************************
  initial begin
    rst_n = 1'b0; cs_n = 1'b1; sclk = 1'b0; host = 1'b0; lock = 1'b0; err_count = 0; n_compared = 0;
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    chk(16'(ua), 16'h01f4);
    for (int k = 0; k < 6; k++) begin
      xfer(1'b1, ofs[k], ~rv[k]);
      chk(rd, rv[k]);
      chk(fw[k], rv[k]);
      xfer(1'b0, ofs[k], 16'hffff);
      xfer(1'b1, ofs[k], ~mk[k]);
      chk(rd, mk[k]);
      chk(fw[k], mk[k]);
    end
    xfer(1'b0, BALUN_TUNING_OFFSET, 16'h0055, 20);
    chk(fw[3], 16'h00ff);
    chk({src, act, bad, 4'h0, stp, div}, 16'he1f8);
    xfer(1'b0, 7'h23, 16'h1234);
    xfer(1'b1, 7'h23, 16'hffff);
    chk(rd, 16'h0000);
    chk(fw[0], 16'h7c3f);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, PUMP_CONTROL_OFFSET, {2'b00, cc[k], 10'h020});
      chk({src, act, 3'h0, ua}, {2'b10, 3'h0, cu[k]});
    end
    xfer(1'b0, OSCILLATOR_CONTROL_OFFSET, 16'h2a0b);
    chk(16'(div), 16'h0004);
    xfer(1'b0, PHASE_DETECTOR_CONTROL_OFFSET, 16'h000b);
    lock <= 1'b1;
    cyc(5);
    chk(16'(lock_out), 16'h0001);
    xfer(1'b0, PHASE_DETECTOR_CONTROL_OFFSET, 16'h001b);
    chk(16'(lock_out), 16'h0000);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
    xfer(1'b1, MODULATOR_TRIM_CONTROL_OFFSET, ~16'h0900);
    chk(rd, 16'h0900);
    chk(fw[2], 16'h2a03);
    finish_test();
  end
  initial begin
    cyc(60000);
    err_count++;
    finish_test();
  end
endmodule : tb
